// [hdl/chassis_monitor_command_handler.sv]
// Decided for this implementation: the Wishbone register port and the address map.
`include "monitor_map.svh"

module chassis_monitor_command_handler #(
  parameter logic [7:0] FW_REVISION = `FW_REVISION_RST, // Arbitrary value
  parameter int SENSORS = `SENSOR_COUNT,
  parameter int THRS = `THR_COUNT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Wishbone slave
  input monitor_pkg::wb_req_t wbReq,
  output monitor_pkg::wb_rsp_t wbRsp,
  // Alarm inputs for the action data
  input wire logic [6:0] railFault,
  input wire logic [2:0] airflowAlarm,
  input wire logic [13:0] tempAlarm,
  // Settings driven to the monitor hardware
  output logic [7:0] tempLimit,
  output logic [7:0] fanSpeed,
  output logic fanHeld,
  output monitor_pkg::cal_t calOffset [SENSORS],
  output logic signed [16:0] threshold [THRS],
  output logic saveReq
);
  import monitor_pkg::*;

  // ----------------------------------------------------------------
  // Bus port and command strobe
  // ----------------------------------------------------------------
  reg_access_t access;
  logic [31:0] readData;
  logic [7:0] cmdCode;
  logic [7:0] cmdArg;
  logic cmdGo;
  logic doCmd;
  logic cmdAccepted;
  logic cmdError;
  logic limitInRange;
  logic fanValid;
  logic [3:0] thrSel;
  logic [7:0] thrMsb;
  logic [15:0] thrQueryMag;
  logic replyLoad;
  logic [4:0][7:0] replyBytes;
  logic [2:0] replyLen;
  logic [7:0] replyHead;
  logic [2:0] replyCount;
  logic replyPop;

  wb_slave_port busPort (
    .ref_clk(ref_clk),
    .srst(srst),
    .wbReq(wbReq),
    .wbRsp(wbRsp),
    .access(access),
    .readData(readData)
  );

  // Both command bytes must be written in one access
  assign cmdCode = access.dat[`F_CODE];
  assign cmdArg = access.dat[`F_ARG];
  assign cmdGo = access.wr && access.adr == `OFS_CMD && (&access.sel[1:0]);
  assign doCmd = cmdGo && cmdAccepted;
  assign replyPop = access.rd && access.adr == `OFS_REPLY;

  // Out-of-range payloads are refused rather than clamped
  assign limitInRange = cmdArg >= `TEMP_LIMIT_MIN && cmdArg <= `TEMP_LIMIT_MAX;
  assign fanValid = cmdArg == `FAN_LOW || cmdArg == `FAN_HIGH || cmdArg == `FAN_AUTO;

  // Magnitude of a signed threshold, for the query reply
  function automatic logic [15:0] thrMag(input logic signed [16:0] v);
    logic [16:0] a;
    a = v[16] ? 17'(-v) : 17'(v);
    return a[15:0];
  endfunction : thrMag

  // ----------------------------------------------------------------
  // Command decode and reply contents
  // ----------------------------------------------------------------
  always_comb begin
    cmdAccepted = 1'b0;
    replyLoad = 1'b0;
    replyBytes = '0;
    replyLen = 3'h0;
    thrQueryMag = 16'h0000;
    if (cmdArg[`F_THR_SEL] <= `THR_LAST) begin
      thrQueryMag = thrMag(threshold[cmdArg[`F_THR_SEL]]);
    end
    unique case (cmdCode)
      `CMD_ACTION_QUERY: begin
        cmdAccepted = 1'b1;
        replyLoad = 1'b1;
        replyBytes[0] = {1'b0, railFault};
        replyBytes[1] = {5'h00, airflowAlarm};
        replyBytes[2] = 8'h00;
        replyBytes[3] = tempAlarm[7:0];
        replyBytes[4] = {2'h0, tempAlarm[13:8]};
        replyLen = `ACTION_LEN;
      end
      `CMD_TEMP_LIMIT_SET: cmdAccepted = limitInRange;
      `CMD_CAL_SET: cmdAccepted = cmdArg[`F_CAL_SENSOR] <= `SENSOR_LAST;
      `CMD_FAN_SET: cmdAccepted = fanValid;
      `CMD_THR_SELECT: cmdAccepted = cmdArg[`F_THR_SEL] <= `THR_LAST;
      `CMD_DEFAULTS, `CMD_THR_MSB, `CMD_THR_LSB, `CMD_SAVE: cmdAccepted = 1'b1;
      `CMD_THR_QUERY: begin
        cmdAccepted = cmdArg[`F_THR_SEL] <= `THR_LAST;
        replyLoad = cmdAccepted;
        replyBytes[0] = thrQueryMag[15:8];
        replyBytes[1] = thrQueryMag[7:0];
        replyLen = `THR_LEN;
      end
      `CMD_FW_QUERY: begin
        cmdAccepted = 1'b1;
        replyLoad = 1'b1;
        replyBytes[0] = FW_REVISION;
        replyLen = `BYTE_LEN;
      end
      `CMD_TEMP_QUERY: begin
        cmdAccepted = 1'b1;
        replyLoad = 1'b1;
        replyBytes[0] = tempLimit;
        replyLen = `BYTE_LEN;
      end
      `CMD_FAN_QUERY: begin
        cmdAccepted = 1'b1;
        replyLoad = 1'b1;
        replyBytes[0] = fanSpeed;
        replyLen = `BYTE_LEN;
      end
      default: cmdAccepted = 1'b0;
    endcase
  end

  // Single-byte replies get a checksum equal to the byte itself
  reply_buffer #(
    .DEPTH(`REPLY_DEPTH)
  ) replyBuf (
    .ref_clk(ref_clk),
    .srst(srst),
    .load(doCmd && replyLoad),
    .loadBytes(replyBytes),
    .loadCount(replyLen),
    .pop(replyPop),
    .head(replyHead),
    .remaining(replyCount)
  );

  // ----------------------------------------------------------------
  // Programmable settings
  // ----------------------------------------------------------------
  // Temperature fault limit
  always_ff @(posedge ref_clk) begin
    if (srst || (doCmd && cmdCode == `CMD_DEFAULTS)) begin
      tempLimit <= `TEMP_LIMIT_RST;
    end else if (doCmd && cmdCode == `CMD_TEMP_LIMIT_SET) begin
      tempLimit <= cmdArg;
    end
  end

  // Fan speed; -1 hands control back to the automatic loop
  always_ff @(posedge ref_clk) begin
    if (srst || (doCmd && cmdCode == `CMD_DEFAULTS)) begin
      fanSpeed <= `FAN_AUTO;
      fanHeld <= 1'b0;
    end else if (doCmd && cmdCode == `CMD_FAN_SET) begin
      fanSpeed <= cmdArg;
      fanHeld <= cmdArg != `FAN_AUTO;
    end
  end

  // Per-sensor calibration offsets
  always_ff @(posedge ref_clk) begin
    if (srst || (doCmd && cmdCode == `CMD_DEFAULTS)) begin
      for (int i = 0; i < SENSORS; i++) begin
        calOffset[i] <= '0;
      end
    end else if (doCmd && cmdCode == `CMD_CAL_SET) begin
      calOffset[cmdArg[`F_CAL_SENSOR]].neg <= cmdArg[`F_CAL_SIGN];
      calOffset[cmdArg[`F_CAL_SENSOR]].mag <= cmdArg[`F_CAL_MAG];
    end
  end

  // Threshold target and stored upper byte
  always_ff @(posedge ref_clk) begin
    if (srst || (doCmd && cmdCode == `CMD_DEFAULTS)) begin
      thrSel <= `THR_SEL_RST;
      thrMsb <= `THR_MSB_RST;
    end else if (doCmd && cmdCode == `CMD_THR_SELECT) begin
      thrSel <= cmdArg[`F_THR_SEL];
    end else if (doCmd && cmdCode == `CMD_THR_MSB) begin
      thrMsb <= cmdArg;
    end
  end

  // Even rail pairs (-2, -5.2, -12, -24 V) are negative: thrSel[1] low
  always_ff @(posedge ref_clk) begin
    if (srst || (doCmd && cmdCode == `CMD_DEFAULTS)) begin
      for (int i = 0; i < THRS; i++) begin
        threshold[i] <= `THR_RST;
      end
    end else if (doCmd && cmdCode == `CMD_THR_LSB) begin
      if (thrSel[1]) begin
        threshold[thrSel] <= 17'({1'b0, thrMsb, cmdArg});
      end else begin
        threshold[thrSel] <= 17'(-{1'b0, thrMsb, cmdArg});
      end
    end
  end

  // Store request; settings stay on the outputs for the writer to copy
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      saveReq <= 1'b0;
    end else begin
      saveReq <= doCmd && cmdCode == `CMD_SAVE;
    end
  end

  // Error reflects the most recent command only
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cmdError <= 1'b0;
    end else if (cmdGo) begin
      cmdError <= !cmdAccepted;
    end
  end

  // ----------------------------------------------------------------
  // Register read mux; unmapped offsets read as zero
  // ----------------------------------------------------------------
  always_comb begin
    readData = '0;
    unique case (access.adr)
      `OFS_REPLY: begin
        readData[`F_REPLY_BYTE] = replyHead;
        readData[`F_REPLY_VALID] = replyCount != 3'h0;
      end
      `OFS_STATUS: begin
        readData[`F_ST_COUNT] = replyCount;
        readData[`F_ST_ERR] = cmdError;
        readData[`F_ST_HELD] = fanHeld;
        readData[`F_ST_SEL] = thrSel;
      end
      `OFS_SETTINGS: begin
        readData[`F_SET_LIMIT] = tempLimit;
        readData[`F_SET_FAN] = fanSpeed;
      end
      default: readData = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  a_limit_in_range: assert property (
    tempLimit >= `TEMP_LIMIT_MIN && tempLimit <= `TEMP_LIMIT_MAX)
    else $error("temperature limit left its legal range");

  a_limit_load: assert property (
    cmdGo && cmdCode == `CMD_TEMP_LIMIT_SET && limitInRange |=> tempLimit == $past(cmdArg))
    else $error("temperature limit not loaded from payload");

  a_cal_offset_load: assert property (
    cmdGo && cmdCode == `CMD_CAL_SET && cmdArg[`F_CAL_SENSOR] == 4'hD
    |=> calOffset[13] == $past(cmdArg[3:0]))
    else $error("inlet sensor offset not loaded");

  a_fan_hold: assert property (
    fanHeld && !(cmdGo && (cmdCode == `CMD_FAN_SET || cmdCode == `CMD_DEFAULTS))
    |=> fanHeld && $stable(fanSpeed))
    else $error("held fan speed changed without a command");

  a_fan_release: assert property (
    cmdGo && cmdCode == `CMD_FAN_SET && cmdArg == `FAN_AUTO
    |=> !fanHeld && fanSpeed == `FAN_AUTO)
    else $error("fan speed -1 did not release the fan");

  a_defaults_restore: assert property (
    cmdGo && cmdCode == `CMD_DEFAULTS
    |=> tempLimit == `TEMP_LIMIT_RST && !fanHeld && thrMsb == `THR_MSB_RST
        && threshold[0] == `THR_RST)
    else $error("defaults not restored");

  a_thr_select: assert property (
    cmdGo && cmdCode == `CMD_THR_SELECT && cmdArg[3:0] <= 4'hD
    |=> thrSel == $past(cmdArg[3:0]))
    else $error("threshold selection not latched");

  a_thr_join: assert property (
    cmdGo && cmdCode == `CMD_THR_LSB
    |=> thrMag(threshold[thrSel]) == {thrMsb, $past(cmdArg)})
    else $error("threshold bytes not joined");

  a_thr_sign: assert property (
    cmdGo && cmdCode == `CMD_THR_LSB && {thrMsb, cmdArg} != 16'h0000
    |=> threshold[thrSel][16] == !thrSel[1])
    else $error("threshold sign does not follow the rail");

  a_action_reply: assert property (
    cmdGo && cmdCode == `CMD_ACTION_QUERY
    |=> replyCount == 3'h6 && replyHead == {1'b0, $past(railFault)})
    else $error("action reply not six bytes starting with rail faults");

  a_revision_twice: assert property (
    cmdGo && cmdCode == `CMD_FW_QUERY
    |=> replyCount == 3'h2 && replyHead == FW_REVISION)
    else $error("revision reply malformed");

  a_save_pulse: assert property (
    cmdGo && cmdCode == `CMD_SAVE |=> saveReq ##1 !saveReq)
    else $error("save request not a single pulse");

  c_action_query: cover property (cmdGo && cmdCode == `CMD_ACTION_QUERY);
  c_fan_hold_release: cover property (fanHeld ##[1:20] !fanHeld);
  c_negative_threshold: cover property (cmdGo && cmdCode == `CMD_THR_LSB && !thrSel[1]);
  c_save: cover property (saveReq);

endmodule : chassis_monitor_command_handler

// [pkg/monitor_map.svh]
`ifndef MONITOR_MAP_SVH
`define MONITOR_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CMD 8'h00
`define OFS_REPLY 8'h04
`define OFS_STATUS 8'h08
`define OFS_SETTINGS 8'h0C

// ----------------------------------------------------------------
// Register fields
// ----------------------------------------------------------------
`define F_CODE 7:0
`define F_ARG 15:8
`define F_REPLY_BYTE 7:0
`define F_REPLY_VALID 8
`define F_ST_COUNT 2:0
`define F_ST_ERR 3
`define F_ST_HELD 4
`define F_ST_SEL 11:8
`define F_SET_LIMIT 7:0
`define F_SET_FAN 15:8

// ----------------------------------------------------------------
// Payload fields
// ----------------------------------------------------------------
`define F_CAL_SENSOR 7:4
`define F_CAL_SIGN 3
`define F_CAL_MAG 2:0
`define F_THR_SEL 3:0

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define CMD_ACTION_QUERY 8'h2C
`define CMD_TEMP_LIMIT_SET 8'h4C
`define CMD_CAL_SET 8'h5C
`define CMD_FAN_SET 8'h6C
`define CMD_DEFAULTS 8'h7C
`define CMD_THR_SELECT 8'h8C
`define CMD_THR_MSB 8'h9C
`define CMD_THR_LSB 8'hAC
`define CMD_THR_QUERY 8'hBC
`define CMD_FW_QUERY 8'hCC
`define CMD_TEMP_QUERY 8'hDC
`define CMD_FAN_QUERY 8'hEC
`define CMD_SAVE 8'h3D

// ----------------------------------------------------------------
// Limits, lengths and reset values
// ----------------------------------------------------------------
`define TEMP_LIMIT_MIN 8'h23
`define TEMP_LIMIT_MAX 8'h69
`define TEMP_LIMIT_RST 8'h37
`define FAN_LOW 8'h00
`define FAN_HIGH 8'h01
`define FAN_AUTO 8'hFF
`define SENSOR_LAST 4'hD
`define THR_LAST 4'hD
`define SENSOR_COUNT 14
`define THR_COUNT 14
`define REPLY_DEPTH 6
`define ACTION_LEN 3'h5
`define THR_LEN 3'h2
`define BYTE_LEN 3'h1
`define THR_RST 17'h0_0000
`define THR_MSB_RST 8'h00
`define THR_SEL_RST 4'h0
`define FW_REVISION_RST 8'h21

`endif

// [pkg/monitor_pkg.sv]
package monitor_pkg;

  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  // Wishbone answer from the slave
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // One-cycle register access, at the acknowledging edge
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } reg_access_t;

  // Sensor calibration offset, magnitude in half degrees
  typedef struct packed {
    logic neg;
    logic [2:0] mag;
  } cal_t;

endpackage : monitor_pkg

// [hdl/wb_slave_port.sv]
module wb_slave_port (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Wishbone side
  input monitor_pkg::wb_req_t wbReq,
  output monitor_pkg::wb_rsp_t wbRsp,
  // Register side
  output monitor_pkg::reg_access_t access,
  input wire logic [31:0] readData
);
  import monitor_pkg::*;

  logic ack;
  logic [31:0] datOut;

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack <= 1'b0;
    end else begin
      ack <= wbReq.cyc & wbReq.stb & ~ack;
    end
  end

  // Read data captured before the ack edge, so a popping read is safe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      datOut <= '0;
    end else if (wbReq.cyc && wbReq.stb && !wbReq.we && !ack) begin
      datOut <= readData;
    end
  end

  assign wbRsp.ack = ack;
  assign wbRsp.dat = datOut;

  // Side effects happen only at the edge the master sees ack
  assign access.wr = wbReq.cyc & wbReq.stb & wbReq.we & ack;
  assign access.rd = wbReq.cyc & wbReq.stb & ~wbReq.we & ack;
  assign access.adr = wbReq.adr;
  assign access.sel = wbReq.sel;
  assign access.dat = wbReq.dat;

  a_ack_single_cycle: assert property (@(posedge ref_clk) disable iff (srst)
    ack |=> !ack)
    else $error("ack held for more than one cycle");

endmodule : wb_slave_port

// [hdl/reply_buffer.sv]
`include "monitor_map.svh"

module reply_buffer #(
  parameter int DEPTH = `REPLY_DEPTH,
  parameter int CW = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Load of a new reply, data bytes only
  input wire logic load,
  input wire logic [DEPTH-2:0][7:0] loadBytes,
  input wire logic [CW-1:0] loadCount,
  // Drain side
  input wire logic pop,
  output logic [7:0] head,
  output logic [CW-1:0] remaining
);
  import monitor_pkg::*;

  logic [7:0] mem [DEPTH];
  logic [7:0] sum;

  // Modulo-256 sum of the data bytes being loaded
  always_comb begin
    sum = 8'h00;
    for (int i = 0; i < DEPTH - 1; i++) begin
      if (i < int'(loadCount)) begin
        sum = sum + loadBytes[i];
      end
    end
  end

  // Shift register keeps the head byte straight out of a flop
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (load) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (i < int'(loadCount)) begin
          mem[i] <= loadBytes[i];
        end else if (i == int'(loadCount)) begin
          mem[i] <= sum;
        end else begin
          mem[i] <= 8'h00;
        end
      end
    end else if (pop && remaining != '0) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        mem[i] <= mem[i+1];
      end
      mem[DEPTH-1] <= 8'h00;
    end
  end

  // A new load replaces whatever was left unread
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      remaining <= '0;
    end else if (load) begin
      remaining <= loadCount + CW'(1);
    end else if (pop && remaining != '0) begin
      remaining <= remaining - CW'(1);
    end
  end

  assign head = mem[0];

  // Helper: sum of stored bytes before the last one
  logic [7:0] storedSum;
  always_comb begin
    storedSum = 8'h00;
    for (int i = 0; i < DEPTH - 1; i++) begin
      if (i + 1 < int'(remaining)) begin
        storedSum = storedSum + mem[i];
      end
    end
  end

  a_checksum_last_byte: assert property (@(posedge ref_clk) disable iff (srst)
    load |=> mem[int'(remaining) - 1] == storedSum)
    else $error("reply checksum is not the sum of its data bytes");

endmodule : reply_buffer

// [test/host_model.sv]
`include "monitor_map.svh"

module host_model (
  // Clock
  input wire logic ref_clk,
  // Wishbone master side
  output monitor_pkg::wb_req_t wbReq,
  input monitor_pkg::wb_rsp_t wbRsp
);
  timeunit 1ns;
  timeprecision 100ps;
  import monitor_pkg::*;

  // Idle bus from time zero
  initial wbReq = '0;

  // One classic cycle; held until ack is sampled, only the bench watchdog ends a wait
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] rdat);
    @(posedge ref_clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    do begin
      @(posedge ref_clk);
    end while (wbRsp.ack !== 1'b1);
    rdat = wbRsp.dat;
    wbReq <= '0;
  endtask : xfer

  // Two-byte command: code, then payload
  task automatic cmd(input logic [7:0] code, input logic [7:0] arg);
    logic [31:0] d;
    xfer(1'b1, `OFS_CMD, {16'h0000, arg, code}, d);
  endtask : cmd

  // Pop one reply byte
  task automatic pop(output logic [31:0] d);
    xfer(1'b0, `OFS_REPLY, 32'h0000_0000, d);
  endtask : pop
endmodule : host_model

// [test/tb_top.sv]
`include "monitor_map.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import monitor_pkg::*;

  // ------------------------------------------------
  // Signals and instances
  // ------------------------------------------------
  localparam logic [7:0] FwRev = 8'h3A; // Arbitrary revision code
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  wb_req_t wbReq;
  wb_rsp_t wbRsp;
  logic [6:0] railFault = 7'h00;
  logic [2:0] airflowAlarm = 3'h0;
  logic [13:0] tempAlarm = 14'h0000;
  logic [7:0] tempLimit;
  logic [7:0] fanSpeed;
  logic fanHeld;
  logic saveReq;
  cal_t calOffset [14];
  logic signed [16:0] threshold [14];
  int errorCnt = 0;
  int checkCount = 0;

  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  host_model host (.ref_clk(ref_clk), .wbReq(wbReq), .wbRsp(wbRsp));

  chassis_monitor_command_handler #(.FW_REVISION(FwRev)) dut (
    .ref_clk(ref_clk), .srst(srst), .wbReq(wbReq), .wbRsp(wbRsp),
    .railFault(railFault), .airflowAlarm(airflowAlarm), .tempAlarm(tempAlarm),
    .tempLimit(tempLimit), .fanSpeed(fanSpeed), .fanHeld(fanHeld),
    .calOffset(calOffset), .threshold(threshold), .saveReq(saveReq));

  // ------------------------------------------------
  // Compare and helper tasks
  // ------------------------------------------------
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkByte

  task automatic chkThr(input logic signed [16:0] got, input logic signed [16:0] exp);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkThr

  // Let the command's updates land before looking
  task automatic settle;
    @(posedge ref_clk);
    #1;
  endtask : settle

  // Pop one byte; it must be flagged valid
  task automatic reply(input logic [7:0] e);
    logic [31:0] d;
    host.pop(d);
    chkByte({7'h00, d[8]}, 8'h01);
    chkByte(d[7:0], e);
  endtask : reply

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_powerup;
    settle;
    chkByte(tempLimit, `TEMP_LIMIT_RST);
    chkByte(fanSpeed, `FAN_AUTO);
    chkByte({7'h00, fanHeld}, 8'h00);
    host.cmd(`CMD_THR_SELECT, 8'h06);
    host.cmd(`CMD_THR_LSB, 8'h55);
    settle;
    chkThr(threshold[6], 17'sh0_0055);
    $display("test powerup done");
  endtask : t_powerup

  task automatic t_limit;
    logic [31:0] d;
    host.cmd(`CMD_TEMP_LIMIT_SET, 8'd35);
    settle;
    chkByte(tempLimit, 8'd35);
    host.cmd(`CMD_TEMP_LIMIT_SET, 8'd105);
    host.cmd(`CMD_TEMP_LIMIT_SET, 8'd106);
    host.xfer(1'b0, `OFS_STATUS, 32'h0000_0000, d);
    chkByte({7'h00, d[`F_ST_ERR]}, 8'h01);
    settle;
    chkByte(tempLimit, 8'd105);
    host.cmd(`CMD_TEMP_QUERY, 8'h14);
    reply(8'd105);
    reply(8'd105);
    $display("test limit done");
  endtask : t_limit

  task automatic t_cal;
    host.cmd(`CMD_CAL_SET, 8'hD0);
    settle;
    chkByte({4'h0, calOffset[13]}, 8'h00);
    host.cmd(`CMD_CAL_SET, 8'hDF);
    host.cmd(`CMD_CAL_SET, 8'h05);
    host.cmd(`CMD_CAL_SET, 8'hE1);
    settle;
    chkByte({4'h0, calOffset[13]}, 8'h0F);
    chkByte({4'h0, calOffset[0]}, 8'h05);
    $display("test cal done");
  endtask : t_cal

  task automatic t_fan;
    host.cmd(`CMD_FAN_SET, `FAN_HIGH);
    host.cmd(`CMD_FAN_SET, 8'h02);
    host.cmd(`CMD_TEMP_LIMIT_SET, 8'd50);
    settle;
    chkByte(fanSpeed, 8'h01);
    chkByte({7'h00, fanHeld}, 8'h01);
    host.cmd(`CMD_FAN_QUERY, 8'h14);
    reply(8'h01);
    reply(8'h01);
    host.cmd(`CMD_FAN_SET, `FAN_LOW);
    settle;
    chkByte(fanSpeed, 8'h00);
    host.cmd(`CMD_FAN_SET, 8'hFF);
    settle;
    chkByte({7'h00, fanHeld}, 8'h00);
    chkByte(fanSpeed, `FAN_AUTO);
    $display("test fan done");
  endtask : t_fan

  task automatic t_thr;
    host.cmd(`CMD_THR_SELECT, 8'hF0);
    host.cmd(`CMD_THR_MSB, 8'h12);
    host.cmd(`CMD_THR_LSB, 8'h34);
    host.cmd(`CMD_THR_SELECT, 8'h03);
    host.cmd(`CMD_THR_MSB, 8'hFF);
    host.cmd(`CMD_THR_LSB, 8'hFE);
    host.cmd(`CMD_THR_SELECT, 8'h0D);
    host.cmd(`CMD_THR_LSB, 8'h01);
    settle;
    chkThr(threshold[0], -17'sh0_1234);
    chkThr(threshold[3], 17'sh0_FFFE);
    chkThr(threshold[13], -17'sh0_FF01);
    chkThr(threshold[6], 17'sh0_0055);
    host.cmd(`CMD_THR_QUERY, 8'h00);
    reply(8'h12);
    reply(8'h34);
    reply(8'h46);
    $display("test thr done");
  endtask : t_thr

  task automatic t_queries;
    logic [7:0] e [6];
    logic [31:0] d;
    e = '{8'h55, 8'h05, 8'h00, 8'hFF, 8'h3F, 8'h98};
    @(posedge ref_clk);
    railFault <= 7'h55;
    airflowAlarm <= 3'h5;
    tempAlarm <= 14'h3FFF;
    settle;
    host.cmd(`CMD_ACTION_QUERY, 8'h14);
    for (int i = 0; i < 6; i++) reply(e[i]);
    host.pop(d);
    chkByte({7'h00, d[8]}, 8'h00);
    host.cmd(`CMD_FW_QUERY, 8'h14);
    reply(FwRev);
    reply(FwRev);
    $display("test queries done");
  endtask : t_queries

  // Pulse must be exactly one cycle wide
  task automatic t_save;
    int n;
    n = 0;
    host.cmd(`CMD_SAVE, 8'h14);
    repeat (4) begin
      #1;
      n += int'(saveReq === 1'b1);
      @(posedge ref_clk);
    end
    chkByte(8'(n), 8'h01);
    $display("test save done");
  endtask : t_save

  task automatic t_defaults;
    logic [31:0] d;
    host.cmd(`CMD_DEFAULTS, 8'h14);
    settle;
    chkByte(tempLimit, `TEMP_LIMIT_RST);
    chkByte(fanSpeed, `FAN_AUTO);
    chkByte({4'h0, calOffset[13]}, 8'h00);
    chkThr(threshold[3], 17'sh0_0000);
    host.xfer(1'b0, `OFS_SETTINGS, 32'h0000_0000, d);
    chkByte(d[`F_SET_LIMIT], `TEMP_LIMIT_RST);
    chkByte(d[`F_SET_FAN], `FAN_AUTO);
    $display("test defaults done");
  endtask : t_defaults

  // Board reset in mid-run must drop a held fan speed
  task automatic t_reset;
    host.cmd(`CMD_FAN_SET, `FAN_HIGH);
    settle;
    chkByte({7'h00, fanHeld}, 8'h01);
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    settle;
    chkByte(fanSpeed, `FAN_AUTO);
    chkByte({7'h00, fanHeld}, 8'h00);
    $display("test reset done");
  endtask : t_reset

  // ------------------------------------------------
  // Run control
  // ------------------------------------------------
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  // Main sequence after a four-cycle reset
  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    t_powerup;
    t_limit;
    t_cal;
    t_fan;
    t_thr;
    t_queries;
    t_save;
    t_defaults;
    t_reset;
    final_report;
  end

  // Watchdog, far beyond the fewer than two hundred cycles needed
  initial begin
    repeat (5000) @(posedge ref_clk);
    errorCnt++;
    final_report;
  end
endmodule : tb_top
